// ===== design/gpst_pkg.sv
// Shared constants and types for the graphics port slice timers.
// Assumes one 50 MHz clock domain and an Avalon-MM word-addressed register slave.
package gpst_pkg;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [7:0]  BASE_IDX     = 8'hB8;
  localparam logic [7:0]  MTT_IDX      = 8'hBC;
  localparam logic [7:0]  LPT_IDX      = 8'hBD;
  localparam logic [7:0]  STATUS_IDX   = 8'hC0;

  localparam logic [31:0] BASE_RESET   = 32'h0000_0000;
  localparam logic [7:0]  TIMER_RESET  = 8'h00;
  // Writable bits: base field 28:12 and timer count field 7:3.
  localparam logic [31:0] BASE_MASK    = 32'h1FFF_F000;
  localparam logic [7:0]  TIMER_MASK   = 8'hF8;
  localparam int          BASE_LSB     = 12;
  localparam int          BASE_MSB     = 28;
  localparam int          CNT_LSB      = 3;
  localparam int          CNT_MSB      = 7;
  localparam int          CNT_W        = CNT_MSB - CNT_LSB + 1;
  // Each count unit is eight port clocks.
  localparam int          SLICE_SHIFT  = 3;
  localparam int          TICK_W       = CNT_W + SLICE_SHIFT;
  // Translation entries are four bytes; 64 MB of 4 KB pages needs 14 index bits.
  localparam int          ENTRY_SHIFT  = 2;
  localparam int          PAGE_IDX_W   = 14;

  typedef enum logic [2:0] {
    GPST_IDLE  = 3'h0,
    GPST_GFX   = 3'h1,
    GPST_HOST  = 3'h3,
    GPST_LOWP  = 3'h2,
    GPST_HIGHP = 3'h6
  } gpst_state_t;

endpackage

// ===== design/gpst_slice_timer.sv
// Tenure timer: counts eight clocks per unit of the programmed count field.
// Assumes load_in is a one-cycle pulse from the arbiter on the same clock.
`timescale 1ns/1ps
module gpst_slice_timer
  import gpst_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] count_in,
  output logic                  expired_out
);

  logic [TICK_W-1:0] remain;
  logic              armed;
  logic [TICK_W-1:0] elapsed;
  logic [CNT_W-1:0]  count_q;

  // A load of N counts expires 8*N-1 edges later, so the grant lasts exactly 8*N clocks.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      remain <= '0;
    end else if (load_in) begin
      remain <= TICK_W'({count_in, {SLICE_SHIFT{1'b0}}} - 1'b1);
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed <= 1'b0;
    end else if (load_in) begin
      armed <= (count_in != '0);
    end
  end

  assign expired_out = armed && (remain == '0);

  // Helper state for the checks below only.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      elapsed <= '0;
      count_q <= '0;
    end else if (load_in) begin
      elapsed <= '0;
      count_q <= count_in;
    end else if (!expired_out) begin
      elapsed <= elapsed + 1'b1;
    end
  end

  AST_SLICE_LENGTH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(expired_out) && !$past(load_in)
      |-> elapsed == TICK_W'({count_q, {SLICE_SHIFT{1'b0}}} - 1'b1))
    else $error("slice timer expired at the wrong cycle");

  AST_ZERO_NEVER_EXPIRES: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    load_in && count_in == '0 |=> !expired_out)
    else $error("zero count armed the slice timer");

endmodule // gpst_slice_timer

// ===== design/gpst_top.sv
// Graphics port arbiter with time-slice timers and translation table base register.
// Assumes requests come from logic on clk_in and an Avalon-MM master drives the register port.
`timescale 1ns/1ps
// Summary of operation
// - Table base register bits 28:12 point at the translation table in memory.
// - Table base is 4 KB aligned; bits 11:0 and 31:29 never form address.
// - Translation fetches form their entry address from the programmed table base.
// - Table base may change anytime; later fetches use the new value.
// - Multi-transaction count sits in bits 7:3, units of eight port clocks.
// - On multi-transaction slice expiry the bus passes to the other of graphics and host, or to high priority, if one waits.
// - Host bridge transactions share the same slice, ensuring fair bandwidth.
// - Multi-transaction count zero, the reset value, disables slicing.
// - Low-priority timer sets minimum tenure for low-priority reads and writes.
// - Low-priority tenure covers consecutive same-type transfers, not just one.
// - After low-priority expiry the bus moves only if another request waits.
// - High-priority requests preempt low-priority tenure immediately.
// - Low-priority count zero, the reset value, disables minimum tenure.
// - Low-priority count sits in bits 7:3, units of eight port clocks.
module gpst_top
  import gpst_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    resetn_in,
  input  wire logic [7:0]              avs_address_in,
  input  wire logic                    avs_read_in,
  input  wire logic                    avs_write_in,
  input  wire logic [31:0]             avs_writedata_in,
  input  wire logic [3:0]              avs_byteenable_in,
  output logic      [31:0]             avs_readdata_out,
  output logic                         avs_waitrequest_out,
  input  wire logic                    gfx_req_in,
  input  wire logic                    host_req_in,
  input  wire logic                    lowp_req_in,
  input  wire logic                    lowp_write_in,
  input  wire logic                    highp_req_in,
  output logic                         gfx_gnt_out,
  output logic                         host_gnt_out,
  output logic                         lowp_gnt_out,
  output logic                         highp_gnt_out,
  input  wire logic                    xlate_req_in,
  input  wire logic [PAGE_IDX_W-1:0]   xlate_page_in,
  output logic                         fetch_valid_out,
  output logic      [31:0]             fetch_addr_out
);

  logic              rst_meta;
  logic              rst_n;
  logic [31:0]       aperture_table_base;
  logic [7:0]        multi_transaction_timer;
  logic [7:0]        low_priority_timer;
  gpst_state_t       state;
  gpst_state_t       next_state;
  logic              last_host;
  logic              lowp_type;
  logic              mt_load;
  logic              lp_load;
  logic              mt_expired;
  logic              lp_expired;
  logic              mt_enabled;
  logic              lp_enabled;
  logic              bus_req;
  logic              bus_take;
  logic              sel_base;
  logic              sel_mtt;
  logic              sel_lpt;
  logic              sel_status;
  logic [31:0]       next_readdata;

  // The reset is released synchronously so no flop leaves reset on a different edge.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Register slave: every access is answered one cycle after it is presented.
  assign bus_req    = avs_read_in || avs_write_in;
  assign bus_take   = bus_req && !avs_waitrequest_out;
  assign sel_base   = (avs_address_in == BASE_IDX);
  assign sel_mtt    = (avs_address_in == MTT_IDX);
  assign sel_lpt    = (avs_address_in == LPT_IDX);
  assign sel_status = (avs_address_in == STATUS_IDX);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !(bus_req && avs_waitrequest_out);
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (sel_base) begin
      next_readdata = aperture_table_base & BASE_MASK;
    end else if (sel_mtt) begin
      next_readdata = {24'h00_0000, multi_transaction_timer};
    end else if (sel_lpt) begin
      next_readdata = {24'h00_0000, low_priority_timer};
    end else if (sel_status) begin
      next_readdata = {23'h00_0000, lp_expired, mt_expired, state, lowp_gnt_out,
                       highp_gnt_out, host_gnt_out, gfx_gnt_out};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      avs_readdata_out <= next_readdata;
    end
  end

  // Writes may land at any time; fetches already issued keep the old base.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      aperture_table_base <= BASE_RESET;
    end else if (avs_write_in && bus_take && sel_base) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable_in[b]) begin
          aperture_table_base[b*8 +: 8] <= avs_writedata_in[b*8 +: 8] & BASE_MASK[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      multi_transaction_timer <= TIMER_RESET;
    end else if (avs_write_in && bus_take && sel_mtt && avs_byteenable_in[0]) begin
      multi_transaction_timer <= avs_writedata_in[7:0] & TIMER_MASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      low_priority_timer <= TIMER_RESET;
    end else if (avs_write_in && bus_take && sel_lpt && avs_byteenable_in[0]) begin
      low_priority_timer <= avs_writedata_in[7:0] & TIMER_MASK;
    end
  end

  // Translation entry address: table base plus four bytes per aperture page.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fetch_valid_out <= 1'b0;
      fetch_addr_out  <= 32'h0000_0000;
    end else begin
      fetch_valid_out <= xlate_req_in;
      if (xlate_req_in) begin
        fetch_addr_out <= {aperture_table_base[31:BASE_LSB], {BASE_LSB{1'b0}}}
                          + {{(32-PAGE_IDX_W-ENTRY_SHIFT){1'b0}}, xlate_page_in,
                             {ENTRY_SHIFT{1'b0}}};
      end
    end
  end

  // Arbiter.
  assign mt_enabled = (multi_transaction_timer[CNT_MSB:CNT_LSB] != '0);
  assign lp_enabled = (low_priority_timer[CNT_MSB:CNT_LSB] != '0);

  function automatic gpst_state_t pick(input logic hp, input logic gfx, input logic host,
                                       input logic lp, input logic prefer_gfx);
    gpst_state_t sel;
    sel = GPST_IDLE;
    if (hp) begin
      sel = GPST_HIGHP;
    end else if (gfx && host) begin
      sel = prefer_gfx ? GPST_GFX : GPST_HOST;
    end else if (gfx) begin
      sel = GPST_GFX;
    end else if (host) begin
      sel = GPST_HOST;
    end else if (lp) begin
      sel = GPST_LOWP;
    end
    return sel;
  endfunction

  always_comb begin
    next_state = state;
    case (state)
      GPST_IDLE: begin
        next_state = pick(highp_req_in, gfx_req_in, host_req_in, lowp_req_in, last_host);
      end
      GPST_GFX: begin
        if (!gfx_req_in) begin
          next_state = pick(highp_req_in, 1'b0, host_req_in, lowp_req_in, 1'b0);
        end else if (mt_enabled && mt_expired && (host_req_in || highp_req_in)) begin
          next_state = highp_req_in ? GPST_HIGHP : GPST_HOST;
        end
      end
      GPST_HOST: begin
        if (!host_req_in) begin
          next_state = pick(highp_req_in, gfx_req_in, 1'b0, lowp_req_in, 1'b1);
        end else if (mt_enabled && mt_expired && (gfx_req_in || highp_req_in)) begin
          next_state = highp_req_in ? GPST_HIGHP : GPST_GFX;
        end
      end
      GPST_LOWP: begin
        if (highp_req_in) begin
          next_state = GPST_HIGHP;
        end else if (!lowp_req_in) begin
          next_state = pick(1'b0, gfx_req_in, host_req_in, 1'b0, last_host);
        end else if ((!lp_enabled || lp_expired) && (gfx_req_in || host_req_in)) begin
          next_state = pick(1'b0, gfx_req_in, host_req_in, 1'b0, last_host);
        end
      end
      GPST_HIGHP: begin
        if (!highp_req_in) begin
          next_state = pick(1'b0, gfx_req_in, host_req_in, lowp_req_in, last_host);
        end
      end
      default: begin
        next_state = GPST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= GPST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gfx_gnt_out   <= 1'b0;
      host_gnt_out  <= 1'b0;
      lowp_gnt_out  <= 1'b0;
      highp_gnt_out <= 1'b0;
    end else begin
      gfx_gnt_out   <= (next_state == GPST_GFX);
      host_gnt_out  <= (next_state == GPST_HOST);
      lowp_gnt_out  <= (next_state == GPST_LOWP);
      highp_gnt_out <= (next_state == GPST_HIGHP);
    end
  end

  // Remembers who last held a slice, so the other agent wins the next tie.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      last_host <= 1'b0;
      lowp_type <= 1'b0;
    end else begin
      if (next_state == GPST_GFX) begin
        last_host <= 1'b0;
      end else if (next_state == GPST_HOST) begin
        last_host <= 1'b1;
      end
      lowp_type <= lowp_write_in;
    end
  end

  // An expired slice with nobody waiting is re-armed so the next contender is timed.
  assign mt_load = ((next_state == GPST_GFX || next_state == GPST_HOST) && next_state != state)
                   || ((state == GPST_GFX || state == GPST_HOST) && next_state == state
                       && mt_expired);
  // Same-type transfers keep one tenure; a change of direction starts a new one.
  assign lp_load = (next_state == GPST_LOWP)
                   && (state != GPST_LOWP || lowp_write_in != lowp_type);

  gpst_slice_timer u_mt_timer (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n),
    .load_in     (mt_load),
    .count_in    (multi_transaction_timer[CNT_MSB:CNT_LSB]),
    .expired_out (mt_expired)
  );

  gpst_slice_timer u_lp_timer (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n),
    .load_in     (lp_load),
    .count_in    (low_priority_timer[CNT_MSB:CNT_LSB]),
    .expired_out (lp_expired)
  );

  AST_BASE_RESERVED: assert property (@(posedge clk_in) disable iff (!rst_n)
    (aperture_table_base & ~BASE_MASK) == 32'h0000_0000)
    else $error("reserved table base bits are set");

  AST_FETCH_ADDR: assert property (@(posedge clk_in) disable iff (!rst_n)
    xlate_req_in ##1 fetch_valid_out |-> fetch_addr_out ==
      {$past(aperture_table_base[31:BASE_LSB]), {BASE_LSB{1'b0}}}
      + {{(32-PAGE_IDX_W-ENTRY_SHIFT){1'b0}}, $past(xlate_page_in), {ENTRY_SHIFT{1'b0}}})
    else $error("fetch address does not follow the table base");

  AST_BASE_WRITE: assert property (@(posedge clk_in) disable iff (!rst_n)
    avs_write_in && bus_take && sel_base && avs_byteenable_in == 4'hF
      |=> aperture_table_base == ($past(avs_writedata_in) & BASE_MASK))
    else $error("table base write was not taken");

  AST_MT_SWITCH: assert property (@(posedge clk_in) disable iff (!rst_n)
    state == GPST_GFX && gfx_req_in && mt_enabled && mt_expired && host_req_in && !highp_req_in
      |=> state == GPST_HOST ##0 host_gnt_out && !gfx_gnt_out)
    else $error("expired slice did not pass to the host");

  AST_HOST_FAIR: assert property (@(posedge clk_in) disable iff (!rst_n)
    state == GPST_HOST && host_req_in && mt_enabled && mt_expired && gfx_req_in && !highp_req_in
      |=> gfx_gnt_out)
    else $error("host slice did not yield to the master");

  AST_MT_DISABLED: assert property (@(posedge clk_in) disable iff (!rst_n)
    state == GPST_GFX && gfx_req_in && !mt_enabled && !highp_req_in |=> state == GPST_GFX)
    else $error("disabled slice timer took the bus away");

  AST_LP_TENURE: assert property (@(posedge clk_in) disable iff (!rst_n)
    state == GPST_LOWP && lowp_req_in && lp_enabled && !lp_expired && !highp_req_in
      |=> lowp_gnt_out)
    else $error("low priority tenure cut short");

  AST_LP_NO_PENDING: assert property (@(posedge clk_in) disable iff (!rst_n)
    state == GPST_LOWP && lowp_req_in && !gfx_req_in && !host_req_in && !highp_req_in
      |=> state == GPST_LOWP)
    else $error("low priority owner lost the bus with no request pending");

  AST_HP_PREEMPT: assert property (@(posedge clk_in) disable iff (!rst_n)
    state == GPST_LOWP && highp_req_in |=> highp_gnt_out && !lowp_gnt_out)
    else $error("high priority request was held off");

  AST_LP_DISABLED: assert property (@(posedge clk_in) disable iff (!rst_n)
    state == GPST_LOWP && !lp_enabled && gfx_req_in && !highp_req_in |=> state != GPST_LOWP)
    else $error("disabled low priority timer still held the bus");

  AST_TIMER_RESERVED: assert property (@(posedge clk_in) disable iff (!rst_n)
    (multi_transaction_timer & ~TIMER_MASK) == 8'h00 && (low_priority_timer & ~TIMER_MASK) == 8'h00)
    else $error("reserved timer bits are set");

  COV_MT_SWITCH: cover property (@(posedge clk_in) disable iff (!rst_n)
    state == GPST_GFX ##1 state == GPST_HOST ##[1:300] state == GPST_GFX);
  COV_LP_PREEMPT: cover property (@(posedge clk_in) disable iff (!rst_n)
    state == GPST_LOWP && highp_req_in);
  COV_LP_EXPIRE: cover property (@(posedge clk_in) disable iff (!rst_n)
    state == GPST_LOWP && lp_expired && gfx_req_in);
  COV_FETCH: cover property (@(posedge clk_in) disable iff (!rst_n)
    fetch_valid_out && fetch_addr_out[BASE_MSB:BASE_LSB] != '0);

endmodule // gpst_top

// ===== tb/gpst_agent_model.sv
// Behavioural requesting agent on the far side of the port arbiter.
// Assumes grants are registered on the same clock; the bench sets want_in as a level.
`timescale 1ns/1ps
module gpst_agent_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        want_in,
  input  wire logic        gnt_in,
  output logic             req_out,
  output logic      [15:0] tenure_out,
  output logic      [15:0] last_tenure_out
);
  // The request is a registered level, as a real master raises it after a clock edge.
  // The tenure counters let the bench measure how long each grant really stood.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_out         <= 1'b0;
      tenure_out      <= 16'h0000;
      last_tenure_out <= 16'h0000;
    end else begin
      req_out <= want_in;
      if (gnt_in) begin
        tenure_out <= tenure_out + 16'h0001;
      end else if (tenure_out != 16'h0000) begin
        last_tenure_out <= tenure_out;
        tenure_out      <= 16'h0000;
      end
    end
  end
endmodule // gpst_agent_model

// ===== tb/tb_graphics_port_slice_timers.sv
// Self-checking bench for the port arbiter, its slice timers and the table base register.
// Assumes the design answers each register access with one cycle of low waitrequest.
`timescale 1ns/1ps
module tb_graphics_port_slice_timers;
  import gpst_pkg::*;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0, wr = 1'b0, xr = 1'b0, lp_wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000, rdata, wait_rd;
  logic [13:0] page = 14'h0000;
  logic [3:0]  want = 4'h0, req, gnt;
  logic        waitreq, wait_s, fv;
  logic [31:0] fa;
  logic [15:0] ten [4], last [4];
  int          error_cnt = 0, n_tests = 0, cyc = 0;

  initial forever #10 clk_in = ~clk_in;

  gpst_top dut_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .gfx_req_in(req[0]), .host_req_in(req[1]), .lowp_req_in(req[2]), .lowp_write_in(lp_wr),
    .highp_req_in(req[3]), .gfx_gnt_out(gnt[0]), .host_gnt_out(gnt[1]),
    .lowp_gnt_out(gnt[2]), .highp_gnt_out(gnt[3]), .xlate_req_in(xr),
    .xlate_page_in(page), .fetch_valid_out(fv), .fetch_addr_out(fa));

  for (genvar i = 0; i < 4; i++) begin : g_agent
    gpst_agent_model agent_u (.clk_in(clk_in), .rst_n_in(resetn_in), .want_in(want[i]),
      .gnt_in(gnt[i]), .req_out(req[i]), .tenure_out(ten[i]), .last_tenure_out(last[i]));
  end

  // Bus outputs are captured half a cycle before each rising edge, so the value seen
  // at that edge never depends on process ordering.
  always @(negedge clk_in) begin
    wait_s  <= waitreq;
    wait_rd <= rdata;
  end

  task automatic end_sim();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    chk_val({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic avs_xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    adr <= idx;
    wd  <= d;
    wr  <= w;
    rd  <= ~w;
    do begin
      @(posedge clk_in);
      n++;
    end while (wait_s !== 1'b0 && n < 50);
    q = wait_rd;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      $display("wrong value t=%0t bus access never answered", $time);
    end
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    avs_xfer(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    avs_xfer(1'b0, idx, 32'h0000_0000, q);
    chk_val(q, exp, "register read");
  endtask

  task automatic wait_gnt(input int i);
    int n;
    n = 0;
    while (gnt[i] !== 1'b1 && n < 100) begin
      @(posedge clk_in);
      n++;
    end
    chk_flag(gnt[i], 1'b1, "grant never came");
    @(negedge clk_in);
  endtask

  task automatic idle(input int n);
    @(posedge clk_in);
    want <= 4'h0;
    repeat (n) @(posedge clk_in);
  endtask

  task automatic fetch_chk(input logic [13:0] p, input logic [31:0] exp);
    @(posedge clk_in);
    xr   <= 1'b1;
    page <= p;
    @(posedge clk_in);
    xr <= 1'b0;
    @(negedge clk_in);
    chk_flag(fv, 1'b1, "fetch strobe");
    chk_val(fa, exp, "fetch address");
  endtask

  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd_chk(BASE_IDX, BASE_RESET);
    rd_chk(MTT_IDX, 32'h0000_0000);
    rd_chk(LPT_IDX, 32'h0000_0000);
    wr_reg(BASE_IDX, 32'hFFFF_FFFF);
    rd_chk(BASE_IDX, 32'h1FFF_F000);
    wr_reg(MTT_IDX, 32'hFFFF_FFFF);
    rd_chk(MTT_IDX, 32'h0000_00F8);
    wr_reg(LPT_IDX, 32'h0000_00FF);
    rd_chk(LPT_IDX, 32'h0000_00F8);
    wr_reg(8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0000_0000);
    // A misaligned base must lose its low bits before forming the entry address.
    wr_reg(BASE_IDX, 32'hF234_5ABC);
    fetch_chk(14'h0003, 32'h1234_500C);
    wr_reg(BASE_IDX, 32'h0ABC_D000);
    fetch_chk(14'h3FFF, 32'h0ABD_CFFC);
    // One unit of count gives eight clocks to each agent in turn.
    wr_reg(MTT_IDX, 32'h0000_0008);
    want[0] <= 1'b1;
    wait_gnt(0);
    want[1] <= 1'b1;
    wait_gnt(1);
    chk_val({16'h0, last[0]}, 32'h0000_0008, "graphics slice");
    wait_gnt(0);
    chk_val({16'h0, last[1]}, 32'h0000_0008, "host slice");
    idle(6);
    wr_reg(MTT_IDX, 32'h0000_0000);
    want[0] <= 1'b1;
    wait_gnt(0);
    want[1] <= 1'b1;
    repeat (40) @(posedge clk_in);
    @(negedge clk_in);
    chk_flag(gnt[0], 1'b1, "slice off keeps owner");
    // Status shows the master granted in its own state with neither slice timer showing expired.
    rd_chk(STATUS_IDX, 32'h0000_0011);
    want[0] <= 1'b0;
    wait_gnt(1);
    idle(6);
    // Two units of low-priority count give sixteen clocks against a waiting master.
    wr_reg(LPT_IDX, 32'h0000_0010);
    want[2] <= 1'b1;
    wait_gnt(2);
    want[0] <= 1'b1;
    wait_gnt(0);
    chk_val({16'h0, last[2]}, 32'h0000_0010, "low priority slice");
    idle(6);
    // A type change six clocks into the tenure starts a fresh one of sixteen clocks.
    want[2] <= 1'b1;
    wait_gnt(2);
    want[0] <= 1'b1;
    repeat (4) @(posedge clk_in);
    lp_wr <= 1'b1;
    wait_gnt(0);
    chk_val({16'h0, last[2]}, 32'h0000_0016, "type change restarts tenure");
    idle(6);
    want[2] <= 1'b1;
    wait_gnt(2);
    repeat (40) @(posedge clk_in);
    @(negedge clk_in);
    chk_flag(gnt[2], 1'b1, "no contender keeps owner");
    chk_flag(ten[2] > 16'h0010, 1'b1, "tenure outlasts slice");
    want[3] <= 1'b1;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk_flag(gnt[3], 1'b1, "high priority preempts");
    idle(6);
    wr_reg(LPT_IDX, 32'h0000_0000);
    want[2] <= 1'b1;
    wait_gnt(2);
    want[0] <= 1'b1;
    wait_gnt(0);
    // Two clocks are the bench's own delay from the grant to the contender's request; the registered grant adds the third.
    chk_val({16'h0, last[2]}, 32'h0000_0003, "zero count yields at once");
    idle(6);
    end_sim();
  end
endmodule // tb_graphics_port_slice_timers
